// [pkg/ccad_pkg.sv]
// package: decode constants, register layout and reset values for the card configuration port
package ccad_pkg;
    // attribute word addresses (byte address a10..a0)
    localparam logic [10:0] CCAD_CFG_BASE      = 11'h200;
    localparam logic [10:0] CCAD_OFS_OPTION    = 11'h200;
    localparam logic [10:0] CCAD_OFS_STATE     = 11'h202;
    localparam logic [10:0] CCAD_OFS_PINSUB    = 11'h204;
    localparam logic [10:0] CCAD_OFS_SOCKET    = 11'h206;
    localparam int          CCAD_ADDR_W        = 11;
    localparam int          CCAD_DATA_W        = 16;
    localparam int          CCAD_INFO_DEPTH    = 256;
    // option register fields
    localparam int          CCAD_OPT_SRST_BIT  = 7;
    localparam int          CCAD_OPT_IMODE_BIT = 6;
    localparam int          CCAD_OPT_IDX_HI    = 5;
    localparam logic [7:0]  CCAD_OPT_RST       = 8'h00;
    localparam logic [7:0]  CCAD_STATE_RST     = 8'h00;
    localparam logic [7:0]  CCAD_PINSUB_RST    = 8'h0C;
    localparam logic [7:0]  CCAD_SOCKET_RST    = 8'h00;
    // strobe synchroniser idle: select, enables, read and write all high
    localparam logic [15:0] CCAD_SYNC_CTL_IDLE = 16'h07C0;
    // state register writable mask (sigchg, io8, pwrdwn)
    localparam logic [7:0]  CCAD_STATE_WMASK   = 8'h64;
    localparam logic [7:0]  CCAD_PINSUB_FIXED  = 8'h0C;
    localparam logic [7:0]  CCAD_SOCKET_WMASK  = 8'h10;
    // configuration index values
    localparam logic [5:0]  CCAD_IDX_MEMORY    = 6'h00;
    localparam logic [5:0]  CCAD_IDX_CONTIG    = 6'h01;
    localparam logic [5:0]  CCAD_IDX_PRIMARY   = 6'h02;
    localparam logic [5:0]  CCAD_IDX_SECOND    = 6'h03;
    // access kinds
    typedef enum logic [3:0] {
        CCAD_ACC_STANDBY,
        CCAD_ACC_IDLE,
        CCAD_ACC_CMEM_LO,
        CCAD_ACC_CMEM_HI,
        CCAD_ACC_CMEM_WORD,
        CCAD_ACC_CFG,
        CCAD_ACC_INFO_RD,
        CCAD_ACC_INVALID
    } ccad_acc_e;
    typedef enum logic [1:0] {
        CCAD_MAP_MEMORY,
        CCAD_MAP_CONTIG,
        CCAD_MAP_PRIMARY,
        CCAD_MAP_SECOND
    } ccad_map_e;
endpackage

// [pkg/ccad_dec_if.sv]
// interface: synchronised host strobes and decoded access between decoder and top
`timescale 1ns/1ns
interface ccad_dec_if;
    import ccad_pkg::*;
    logic        attr_sel_n;
    logic        low_byte_enable_n;
    logic        high_byte_enable_n;
    logic        rd_n;
    logic        wr_n;
    logic [10:0] addr;
    ccad_acc_e   kind;
    logic [1:0]  cfg_sel;
    logic        cfg_hit;
    modport src (output attr_sel_n, output low_byte_enable_n, output high_byte_enable_n,
                 output rd_n, output wr_n, output addr, input kind, input cfg_sel, input cfg_hit);
    modport dec (input attr_sel_n, input low_byte_enable_n, input high_byte_enable_n,
                 input rd_n, input wr_n, input addr, output kind, output cfg_sel, output cfg_hit);
endinterface

// [hdl/ccad_decode.sv]
// module: combinational decode of the host access kind and register select
`timescale 1ns/1ns
module ccad_decode
    import ccad_pkg::*;
(
    ccad_dec_if.dec d
);
    logic cfg_space;
    // configuration space ignores the high enable entirely
    assign cfg_space = !d.attr_sel_n && !d.low_byte_enable_n && d.addr[9] && !d.addr[0];
    // only 200h..206h even are real registers; rest of a9 space reads zero
    assign d.cfg_hit = cfg_space && !d.addr[10] && (d.addr[8:3] == 6'h00);
    assign d.cfg_sel = d.addr[2:1];

    always_comb begin
        d.kind = CCAD_ACC_IDLE;
        if (d.low_byte_enable_n && d.high_byte_enable_n) begin
            d.kind = CCAD_ACC_STANDBY;
        end else if (d.attr_sel_n) begin
            if (!d.low_byte_enable_n && d.high_byte_enable_n) begin
                d.kind = CCAD_ACC_CMEM_LO;
            end else if (d.low_byte_enable_n && !d.high_byte_enable_n) begin
                d.kind = CCAD_ACC_CMEM_HI;
            end else if (!d.addr[0]) begin
                d.kind = CCAD_ACC_CMEM_WORD;
            end else begin
                d.kind = CCAD_ACC_INVALID;
            end
        end else if (d.low_byte_enable_n || d.addr[0]) begin
            d.kind = CCAD_ACC_INVALID;
        end else if (d.addr[9]) begin
            d.kind = CCAD_ACC_CFG;
        end else if (!d.addr[10] && !d.rd_n && d.wr_n) begin
            d.kind = CCAD_ACC_INFO_RD;
        end else begin
            d.kind = CCAD_ACC_INVALID;
        end
    end
endmodule

// [hdl/ccad_info_rom.sv]
// module: attribute information structure byte store, read only
`timescale 1ns/1ns
module ccad_info_rom
    import ccad_pkg::*;
#(
    parameter int DEPTH = CCAD_INFO_DEPTH
)(
    input  wire logic [$clog2(DEPTH)-1:0] index,
    output logic      [7:0]               data
);
    logic [7:0] mem [DEPTH];
    // fixed tuple content; a real part loads its own table here
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_fill
            if (i == 0) begin : g_first
                assign mem[i] = 8'h01;
            end else begin : g_rest
                assign mem[i] = 8'hFF;
            end
        end
    endgenerate
    assign data = mem[index];
endmodule

// [hdl/ccad_top.sv]
// module: parallel host port decode with card configuration registers
`timescale 1ns/1ns
module ccad_top
    import ccad_pkg::*;
#(
    parameter int INFO_DEPTH = CCAD_INFO_DEPTH
)(
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic                   attr_sel_n,
    input  wire logic                   low_byte_enable_n,
    input  wire logic                   high_byte_enable_n,
    input  wire logic                   rd_n,
    input  wire logic                   wr_n,
    input  wire logic [10:0]            addr,
    input  wire logic [15:0]            data_in,
    input  wire logic                   core_irq,
    input  wire logic                   core_ready,
    input  wire logic [15:0]            cmem_rdata,
    output logic      [15:0]            data_out,
    output logic      [1:0]             data_oe,
    output logic                        cmem_rd,
    output logic                        cmem_wr,
    output logic      [1:0]             cmem_lanes,
    output logic      [10:0]            cmem_addr,
    output logic      [15:0]            cmem_wdata,
    output logic                        card_reset,
    output logic                        irq_out,
    output logic                        io_mode,
    output logic      [1:0]             map_mode,
    output logic                        status_chg_n
);
    // two-flop synchronisers for all host pins
    typedef struct packed {
        logic [15:0] s1_ctl;
        logic [15:0] s2_ctl;
        logic [15:0] s1_dat;
        logic [15:0] s2_dat;
        logic        irq_s1;
        logic        irq_s2;
        logic        rdy_s1;
        logic        rdy_s2;
    } ccad_sync_s;

    typedef struct packed {
        logic [7:0]  option;
        logic [7:0]  state;
        logic [7:0]  pinsub;
        logic [7:0]  socket;
        logic        wr_prev;
        logic        rd_prev;
        logic        rdy_prev;
        logic        irq_prev;
        logic [15:0] dout;
        logic [1:0]  oe;
        logic        cmem_rd;
        logic        cmem_wr;
        logic [1:0]  lanes;
        logic [10:0] caddr;
        logic [15:0] cwdata;
        logic        crst;
        logic        irq;
        logic        iomode;
        logic [1:0]  map;
        logic        chg_n;
    } ccad_state_s;

    ccad_sync_s  sy_q;
    ccad_sync_s  sy_d;
    ccad_state_s st_q;
    ccad_state_s st_d;
    ccad_dec_if  dif ();
    logic [7:0]  info_byte;
    logic [7:0]  cfg_rdata;
    logic [7:0]  wbyte;
    logic        wr_edge;
    logic        rd_act;
    ccad_acc_e   kind;

    // synchroniser stage packing; only s2 is read by logic
    always_comb begin
        sy_d        = sy_q;
        sy_d.s1_ctl = {5'h00, attr_sel_n, low_byte_enable_n, high_byte_enable_n, rd_n, wr_n, 6'h00};
        sy_d.s2_ctl = sy_q.s1_ctl;
        sy_d.s1_dat = data_in;
        sy_d.s2_dat = sy_q.s1_dat;
        sy_d.irq_s1 = core_irq;
        sy_d.irq_s2 = sy_q.irq_s1;
        sy_d.rdy_s1 = core_ready;
        sy_d.rdy_s2 = sy_q.rdy_s1;
    end

    // address bus synchronised separately to keep struct compact
    logic [10:0] addr_s1_q;
    logic [10:0] addr_s2_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sy_q        <= '0;
            // strobes reset to idle high so no false write edge follows reset
            sy_q.s1_ctl <= CCAD_SYNC_CTL_IDLE;
            sy_q.s2_ctl <= CCAD_SYNC_CTL_IDLE;
            addr_s1_q <= 11'h000;
            addr_s2_q <= 11'h000;
        end else begin
            sy_q      <= sy_d;
            addr_s1_q <= addr;
            addr_s2_q <= addr_s1_q;
        end
    end

    assign dif.attr_sel_n         = sy_q.s2_ctl[10];
    assign dif.low_byte_enable_n  = sy_q.s2_ctl[9];
    assign dif.high_byte_enable_n = sy_q.s2_ctl[8];
    assign dif.rd_n               = sy_q.s2_ctl[7];
    assign dif.wr_n               = sy_q.s2_ctl[6];
    assign dif.addr               = addr_s2_q;

    ccad_decode u_dec (
        .d (dif)
    );

    ccad_info_rom #(
        .DEPTH (INFO_DEPTH)
    ) u_info (
        .index (addr_s2_q[$clog2(INFO_DEPTH):1]),
        .data  (info_byte)
    );

    assign kind    = dif.kind;
    assign wbyte   = sy_q.s2_dat[7:0];
    // write acts once on the falling strobe edge
    assign wr_edge = st_q.wr_prev && !dif.wr_n;
    assign rd_act  = !dif.rd_n && dif.wr_n;

    // register read mux; pin status visible through registers
    always_comb begin
        cfg_rdata = 8'h00;
        if (dif.cfg_hit) begin
            case (dif.cfg_sel)
                2'd0: cfg_rdata = st_q.option;
                2'd1: cfg_rdata = {st_q.state[7:1], 1'b0}; // request level, not the pulse
                2'd2: cfg_rdata = st_q.pinsub | CCAD_PINSUB_FIXED;
                2'd3: cfg_rdata = st_q.socket;
                default: cfg_rdata = 8'h00;
            endcase
        end
    end

    always_comb begin
        st_d          = st_q;
        st_d.wr_prev  = dif.wr_n;
        st_d.rd_prev  = dif.rd_n;
        st_d.rdy_prev = sy_q.rdy_s2;
        st_d.irq_prev = sy_q.irq_s2;
        st_d.cmem_rd  = 1'b0;
        st_d.cmem_wr  = 1'b0;
        st_d.oe       = 2'b00;
        st_d.dout     = 16'h0000;
        st_d.caddr    = dif.addr;
        st_d.cwdata   = sy_q.s2_dat;
        // pin substitute ready change flag (bit 5) latches on ready transitions; set wins
        if (sy_q.rdy_s2 != st_q.rdy_prev) begin
            st_d.pinsub[5] = 1'b1;
        end
        st_d.pinsub[1] = sy_q.rdy_s2;
        case (kind)
            CCAD_ACC_STANDBY: begin
                st_d.lanes = 2'b00;
            end
            CCAD_ACC_CMEM_LO: begin
                st_d.lanes   = 2'b01;
                st_d.cmem_rd = rd_act && st_q.rd_prev;
                st_d.cmem_wr = wr_edge;
                st_d.oe      = rd_act ? 2'b01 : 2'b00;
                st_d.dout    = {8'h00, cmem_rdata[7:0]};
            end
            CCAD_ACC_CMEM_HI: begin
                st_d.lanes   = 2'b10;
                st_d.cmem_rd = rd_act && st_q.rd_prev;
                st_d.cmem_wr = wr_edge;
                st_d.oe      = rd_act ? 2'b10 : 2'b00;
                st_d.dout    = {cmem_rdata[15:8], 8'h00};
            end
            CCAD_ACC_CMEM_WORD: begin
                st_d.lanes   = 2'b11;
                st_d.cmem_rd = rd_act && st_q.rd_prev;
                st_d.cmem_wr = wr_edge;
                st_d.oe      = rd_act ? 2'b11 : 2'b00;
                st_d.dout    = cmem_rdata;
            end
            CCAD_ACC_INFO_RD: begin
                st_d.oe   = 2'b01;
                st_d.dout = {8'h00, info_byte};
            end
            CCAD_ACC_CFG: begin
                if (rd_act) begin
                    st_d.oe   = 2'b01;
                    st_d.dout = {8'h00, cfg_rdata};
                end
                if (wr_edge && dif.cfg_hit) begin
                    case (dif.cfg_sel)
                        2'd0: st_d.option = wbyte;
                        2'd1: st_d.state = (st_q.state & ~CCAD_STATE_WMASK) | (wbyte & CCAD_STATE_WMASK);
                        2'd2: begin
                            // mask bits gate the change flags; a ready edge still sets
                            if (wbyte[1]) begin
                                st_d.pinsub[5] = wbyte[5] | (sy_q.rdy_s2 != st_q.rdy_prev);
                            end
                            if (wbyte[0]) begin
                                st_d.pinsub[4] = wbyte[4];
                            end
                        end
                        2'd3: st_d.socket = wbyte & CCAD_SOCKET_WMASK;
                        default: st_d.option = st_q.option;
                    endcase
                end
            end
            default: begin
                st_d.lanes = 2'b00;
            end
        endcase
        // soft reset: bit stays, rest of option, state and pinsub back to unconfigured; socket keeps its value
        st_d.crst = st_d.option[CCAD_OPT_SRST_BIT];
        if (st_q.option[CCAD_OPT_SRST_BIT]) begin
            st_d.option[CCAD_OPT_SRST_BIT-1:0] = CCAD_OPT_RST[CCAD_OPT_SRST_BIT-1:0];
            st_d.state  = CCAD_STATE_RST;
            st_d.pinsub = CCAD_PINSUB_RST;
            if (!(wr_edge && dif.cfg_hit && dif.cfg_sel == 2'd0)) begin
                st_d.option[CCAD_OPT_SRST_BIT] = 1'b1;
            end
        end
        // index decode to mapping; unknown indices fall back to memory
        case (st_d.option[CCAD_OPT_IDX_HI:0])
            CCAD_IDX_CONTIG:  st_d.map = CCAD_MAP_CONTIG;
            CCAD_IDX_PRIMARY: st_d.map = CCAD_MAP_PRIMARY;
            CCAD_IDX_SECOND:  st_d.map = CCAD_MAP_SECOND;
            default:          st_d.map = CCAD_MAP_MEMORY;
        endcase
        st_d.iomode = (st_d.option[CCAD_OPT_IDX_HI:0] != CCAD_IDX_MEMORY);
        // level mode follows request; pulse mode one clock per rising request
        if (st_q.option[CCAD_OPT_IMODE_BIT]) begin
            st_d.irq = sy_q.irq_s2;
        end else begin
            st_d.irq = sy_q.irq_s2 && !st_q.irq_prev;
        end
        st_d.state[1] = sy_q.irq_s2;
        st_d.state[7] = st_d.pinsub[5] | st_d.pinsub[4];
        st_d.chg_n    = !(st_d.state[7] && st_d.state[6] && st_d.iomode);
    end

    // whole state resets to power-up values
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q         <= '0;
            st_q.option  <= CCAD_OPT_RST;
            st_q.state   <= CCAD_STATE_RST;
            st_q.pinsub  <= CCAD_PINSUB_RST;
            st_q.socket  <= CCAD_SOCKET_RST;
            st_q.wr_prev <= 1'b1;
            st_q.rd_prev <= 1'b1;
            st_q.chg_n   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign data_out     = st_q.dout;
    assign data_oe      = st_q.oe;
    assign cmem_rd      = st_q.cmem_rd;
    assign cmem_wr      = st_q.cmem_wr;
    assign cmem_lanes   = st_q.lanes;
    assign cmem_addr    = st_q.caddr;
    assign cmem_wdata   = st_q.cwdata;
    assign card_reset   = st_q.crst;
    assign irq_out      = st_q.irq;
    assign io_mode      = st_q.iomode;
    assign map_mode     = st_q.map;
    assign status_chg_n = st_q.chg_n;

    // standby never drives the data bus
    standby_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
        (kind == CCAD_ACC_STANDBY) |=> (data_oe == 2'b00))
        else $error("data driven in standby");
    // option write lands next cycle
    option_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_edge && dif.cfg_hit && dif.cfg_sel == 2'd0 && !st_q.option[7]) |=> (st_q.option == $past(wbyte)))
        else $error("option write lost");
    // info area write leaves option and socket unchanged
    info_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_edge && kind == CCAD_ACC_INVALID && !st_q.option[7]) |=> $stable(st_q.option) && $stable(st_q.socket))
        else $error("invalid write changed state");
    // soft reset holds reset output while bit set
    soft_reset_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_q.option[7] |-> card_reset)
        else $error("soft reset not applied");
    // soft reset clears the index
    soft_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        ($past(st_q.option[7]) && st_q.option[7]) |-> (st_q.option[5:0] == 6'h00))
        else $error("index survived soft reset");
    // pulse mode gives single cycle requests
    pulse_irq_a: assert property (@(posedge clk) disable iff (!arst_n)
        (irq_out && !st_q.option[6] && !$past(st_q.option[6])) |=> !irq_out)
        else $error("pulse request too long");
    // word access drives both lanes on read
    word_lanes_a: assert property (@(posedge clk) disable iff (!arst_n)
        (kind == CCAD_ACC_CMEM_WORD && rd_act) |=> (data_oe == 2'b11))
        else $error("word read lanes wrong");
    // high enable alone drives upper lane only
    high_lane_a: assert property (@(posedge clk) disable iff (!arst_n)
        (kind == CCAD_ACC_CMEM_HI && rd_act) |=> (data_oe == 2'b10))
        else $error("high byte lane wrong");
    // mapping follows the primary index
    map_index_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st_q.option[5:0] == CCAD_IDX_PRIMARY) |-> (map_mode == CCAD_MAP_PRIMARY))
        else $error("mapping mismatch");
    // information structure read drives the low lane only
    info_read_a: assert property (@(posedge clk) disable iff (!arst_n)
        (kind == CCAD_ACC_INFO_RD) |=> (data_oe == 2'b01))
        else $error("info read lanes wrong");
endmodule

// [testbench/ccad_host_model.sv]
// host socket model: drives card pins with held strobes
`timescale 1ns/1ns
module ccad_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] data_out,
    input  wire logic [1:0]  data_oe,
    output logic             attr_sel_n,
    output logic             low_byte_enable_n,
    output logic             high_byte_enable_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic [10:0]      addr,
    output logic [15:0]      data_in
);
    // idle: deselected, buses scrambled so no stale value looks valid
    initial begin
        {attr_sel_n, low_byte_enable_n, high_byte_enable_n, rd_n, wr_n} = 5'h1F;
        addr = 11'h5AA;
        data_in = 16'hA5A5;
    end
    // one access: set after a falling edge, held, answer taken, released
    task automatic acc(input logic r, input logic [1:0] ce, input logic we, input logic [10:0] a,
                       input logic [15:0] wd, output logic [15:0] rdat, output logic [1:0] oe);
        @(negedge clk);
        attr_sel_n = r;
        {high_byte_enable_n, low_byte_enable_n} = ce;
        addr = a;
        data_in = wd;
        rd_n = we;
        wr_n = ~we; // attribute writes kept to register addresses except on purpose
        repeat (6) @(negedge clk);
        rdat = data_out;
        oe = data_oe;
        {attr_sel_n, low_byte_enable_n, high_byte_enable_n, rd_n, wr_n} = 5'h1F;
        addr = ~a;
        data_in = ~wd;
        // gap longer than the two synchroniser clocks
        repeat (4) @(negedge clk);
    endtask
endmodule

// [testbench/tb_top.sv]
// testbench: host accesses to the card configuration port
`timescale 1ns/1ns
module tb_top;
    import ccad_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        core_irq = 1'b0;
    logic        core_ready = 1'b0;
    logic [15:0] cmem_rdata = 16'hA55A;
    logic        attr_sel_n, low_byte_enable_n, high_byte_enable_n, rd_n, wr_n;
    logic [10:0] addr, cmem_addr, la;
    logic [15:0] data_in, data_out, cmem_wdata, rv, lw, m;
    logic [1:0]  data_oe, cmem_lanes, ro, ll, lane;
    logic        cmem_rd, cmem_wr, card_reset, irq_out, io_mode, status_chg_n;
    logic [1:0]  map_mode;
    int          n_errors = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          nwr = 0;
    int          nirq = 0;
    int          nrd = 0;

    always #5 clk = ~clk;

    ccad_host_model ccad_host_model_inst (.clk(clk), .data_out(data_out), .data_oe(data_oe),
        .attr_sel_n(attr_sel_n), .low_byte_enable_n(low_byte_enable_n),
        .high_byte_enable_n(high_byte_enable_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in));

    ccad_top ccad_top_inst (.clk(clk), .arst_n(arst_n), .attr_sel_n(attr_sel_n),
        .low_byte_enable_n(low_byte_enable_n), .high_byte_enable_n(high_byte_enable_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .data_in(data_in), .core_irq(core_irq), .core_ready(core_ready),
        .cmem_rdata(cmem_rdata), .data_out(data_out), .data_oe(data_oe), .cmem_rd(cmem_rd),
        .cmem_wr(cmem_wr), .cmem_lanes(cmem_lanes), .cmem_addr(cmem_addr), .cmem_wdata(cmem_wdata),
        .card_reset(card_reset), .irq_out(irq_out), .io_mode(io_mode), .map_mode(map_mode),
        .status_chg_n(status_chg_n));

    // one-cycle outputs are caught here; the cycle ceiling cuts a hang
    always @(posedge clk) begin
        cyc++;
        if (cmem_wr === 1'b1) begin
            nwr++;
            lw = cmem_wdata;
            ll = cmem_lanes;
            la = cmem_addr;
        end
        if (irq_out === 1'b1) begin
            nirq++;
        end
        if (cmem_rd === 1'b1) begin
            nrd++;
        end
        if (cyc == 4000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({15'h0, got}, {15'h0, exp});
    endtask
    task automatic ac(input logic r, input logic [1:0] c, input logic w, input logic [10:0] a,
                      input logic [15:0] d);
        ccad_host_model_inst.acc(r, c, w, a, d, rv, ro);
    endtask
    // attribute byte read on the low lane only
    task automatic rdc(input logic [10:0] a, input logic [7:0] e);
        ac(1'b0, 2'b10, 1'b0, a, 16'h0);
        chk_val({14'h0, ro}, 16'h1);
        chk_val({8'h0, rv[7:0]}, {8'h0, e});
    endtask
    task automatic wrc(input logic [10:0] a, input logic [7:0] d);
        ac(1'b0, 2'b10, 1'b1, a, {8'h0, d});
    endtask
    task automatic summarize();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        rdc(11'h000, 8'h01);
        rdc(CCAD_OFS_OPTION, 8'h00);
        rdc(CCAD_OFS_STATE, 8'h00);
        rdc(CCAD_OFS_PINSUB, 8'h0C);
        rdc(CCAD_OFS_SOCKET, 8'h00);
        // each of the four defined index values with its mapping and card mode
        for (int i = 0; i < 4; i++) begin
            wrc(CCAD_OFS_OPTION, {2'b01, 6'(i)});
            rdc(CCAD_OFS_OPTION, {2'b01, 6'(i)});
            chk_val({14'h0, map_mode}, 16'(i));
            chk_bit(io_mode, i != 0);
        end
        // masked writes; a host-set change flag shows as status in i/o mode
        wrc(CCAD_OFS_STATE, 8'hFF);
        rdc(CCAD_OFS_STATE, 8'h64);
        wrc(CCAD_OFS_PINSUB, 8'h22);
        rdc(CCAD_OFS_PINSUB, 8'h2C);
        rdc(CCAD_OFS_STATE, 8'hE4);
        chk_bit(status_chg_n, 1'b0);
        wrc(CCAD_OFS_PINSUB, 8'h02);
        // a ready transition sets its change flag and shows the live level
        core_ready = 1'b1;
        rdc(CCAD_OFS_PINSUB, 8'h2E);
        wrc(CCAD_OFS_PINSUB, 8'h02);
        rdc(CCAD_OFS_PINSUB, 8'h0E);
        wrc(CCAD_OFS_SOCKET, 8'hFF);
        rdc(CCAD_OFS_SOCKET, 8'h10);
        ac(1'b0, 2'b00, 1'b1, CCAD_OFS_OPTION, 16'h0003);
        rdc(CCAD_OFS_OPTION, 8'h03);
        // refused attribute accesses leave everything alone
        ac(1'b0, 2'b10, 1'b1, 11'h201, 16'h00FF);
        ac(1'b0, 2'b01, 1'b1, CCAD_OFS_OPTION, 16'hFFFF);
        ac(1'b0, 2'b10, 1'b0, 11'h201, 16'h0);
        chk_val({14'h0, ro}, 16'h0);
        ac(1'b0, 2'b01, 1'b0, CCAD_OFS_OPTION, 16'h0);
        chk_val({14'h0, ro}, 16'h0);
        rdc(CCAD_OFS_OPTION, 8'h03);
        wrc(11'h000, 8'h55);
        rdc(11'h000, 8'h01);
        // common memory lanes: low, high, word
        for (int k = 1; k < 4; k++) begin
            lane = 2'(k);
            m = {{8{lane[1]}}, {8{lane[0]}}};
            nrd = 0;
            ac(1'b1, ~lane, 1'b0, 11'h010, 16'h0);
            chk_val({14'h0, ro}, {14'h0, lane});
            chk_val(rv & m, cmem_rdata & m);
            chk_bit(nrd != 0, 1'b1);
            ac(1'b1, ~lane, 1'b1, 11'h012, 16'hC33C);
            chk_val(16'(nwr), 16'(k));
            chk_val({14'h0, ll}, {14'h0, lane});
            chk_val(lw & m, 16'hC33C & m);
            chk_val({5'h0, la}, 16'h0012);
        end
        nrd = 0;
        ac(1'b0, 2'b11, 1'b0, CCAD_OFS_OPTION, 16'h0);
        chk_val({14'h0, ro}, 16'h0);
        ac(1'b1, 2'b11, 1'b1, 11'h012, 16'h1234);
        chk_val(16'(nwr), 16'h3);
        chk_val(16'(nrd), 16'h0);
        // pulse mode then level mode requests
        wrc(CCAD_OFS_OPTION, 8'h00);
        nirq = 0;
        core_irq = 1'b1;
        repeat (10) @(negedge clk);
        chk_val(16'(nirq), 16'h1);
        rdc(CCAD_OFS_STATE, 8'h66);
        core_irq = 1'b0;
        wrc(CCAD_OFS_OPTION, 8'h40);
        core_irq = 1'b1;
        repeat (10) @(negedge clk);
        chk_bit(irq_out, 1'b1);
        core_irq = 1'b0;
        // soft reset holds its own bit, clears the rest, then releases
        wrc(CCAD_OFS_OPTION, 8'h83);
        chk_bit(card_reset, 1'b1);
        chk_bit(io_mode, 1'b0);
        rdc(CCAD_OFS_OPTION, 8'h80);
        rdc(CCAD_OFS_STATE, 8'h00);
        wrc(CCAD_OFS_OPTION, 8'h00);
        chk_bit(card_reset, 1'b0);
        rdc(CCAD_OFS_OPTION, 8'h00);
        // hardware reset in mid-run with the soft reset bit set
        wrc(CCAD_OFS_OPTION, 8'hC1);
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        chk_bit(card_reset, 1'b0);
        rdc(CCAD_OFS_OPTION, 8'h00);
        summarize();
    end
endmodule
